/* File: pci_interrupt_and_config_access_test.sv */
// self-checking bench for the pci interrupt and hook block
`timescale 1ns/1ps
module pci_interrupt_and_config_access_test;
	localparam logic [31:0] HVD = 32'hA5A5_0001; // arbitrary value
	localparam logic [31:0] HCR = 32'h0000_0002; // arbitrary value
	logic               clk, sys_rst, psel, penable, pwrite;
	logic               pready, pslverr, slvErr, pciClk, pciRst_n, powerD0;
	logic               hostIrqPinIn, hostIrqPinOut, hostIrqPinOe, localCpuIrq;
	logic [7:0]         paddr;
	logic [31:0]        pwdata, prdata, hostRdata, rd;
	pic_pkg::pic_evt_t  pciEvt;
	pic_pkg::pic_host_t hostAcc;
	int                 mismatches, num_checks, cycles;
	// open-drain wire with a pull-up
	assign hostIrqPinIn = hostIrqPinOe ? hostIrqPinOut : 1'b1;
	pic_host_model host_u (.pciClk(pciClk), .pciEvt(pciEvt), .hostAcc(hostAcc));
	pic_irq_cfg #(.HOOK_VD_RST(HVD), .HOOK_CR_RST(HCR)) dut_u (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pciClk(pciClk),
		.pciRst_n(pciRst_n), .powerD0(powerD0), .pciEvt(pciEvt),
		.hostAcc(hostAcc), .hostRdata(hostRdata),
		.hostIrqPinIn(hostIrqPinIn), .hostIrqPinOut(hostIrqPinOut),
		.hostIrqPinOe(hostIrqPinOe), .localCpuIrq(localCpuIrq));
	// clock and hang guard; the whole run needs well under 8000 cycles
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (mismatches == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// apb master: setup, access until pready, take data at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		slvErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, string n);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, rd, e);
	endtask : rdc
	// enable masks: reset, set, clear, zero bits, unmapped place
	task automatic t_masks();
		rdc(pic_pkg::OFF_HOST_SET, 32'h0000_0000, "host mask rst");
		rdc(pic_pkg::OFF_LOCAL_SET, 32'h0000_0000, "local mask rst");
		apb(1'b1, 8'h30, 32'h0000_00FF);
		chk("unmapped err", {31'b0, slvErr}, 32'h0000_0001);
		apb(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_0005);
		apb(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_0002);
		rdc(pic_pkg::OFF_HOST_SET, 32'h0000_0007, "host set");
		apb(1'b1, pic_pkg::OFF_HOST_CLR, 32'h0000_0001);
		rdc(pic_pkg::OFF_HOST_SET, 32'h0000_0006, "host clr");
		apb(1'b1, pic_pkg::OFF_LOCAL_SET, 32'h0000_000C);
		apb(1'b1, pic_pkg::OFF_LOCAL_SET, 32'h0000_0001);
		rdc(pic_pkg::OFF_LOCAL_SET, 32'h0000_000D, "loc set");
		apb(1'b1, pic_pkg::OFF_LOCAL_CLR, 32'h0000_0004);
		rdc(pic_pkg::OFF_LOCAL_SET, 32'h0000_0009, "loc clr");
		apb(1'b1, pic_pkg::OFF_HOST_CLR, 32'h0000_00FF);
		apb(1'b1, pic_pkg::OFF_LOCAL_CLR, 32'h0000_00FF);
	endtask : t_masks
	// every event kind; parity routed to host only, target abort to local only, the rest to neither
	task automatic t_events();
		logic [7:0] ev [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h04, 8'h08};
		apb(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_0001);
		apb(1'b1, pic_pkg::OFF_LOCAL_SET, 32'h0000_0008);
		for (int i = 0; i < 6; i++) begin
			host_u.strobe(6'b10_0000 >> i);
			repeat (12) @(posedge clk);
			rdc(pic_pkg::OFF_STATUS, {24'b0, ev[i]}, "status");
			chk("host pin", {31'b0, hostIrqPinOe}, ev[i] == 8'h01);
			chk("local irq", {31'b0, localCpuIrq}, ev[i] == 8'h08);
			rdc(pic_pkg::OFF_HOST_CLR, {24'b0, ev[i] & 8'h01}, "h src");
			rdc(pic_pkg::OFF_LOCAL_CLR, {24'b0, ev[i] & 8'h08}, "l src");
			rdc(pic_pkg::OFF_PIN_STATE, {30'b0, 1'b1, ev[i] != 8'h01}, "wire");
			apb(1'b1, pic_pkg::OFF_STATUS, 32'h0000_00FF);
		end
	endtask : t_events
	// software bits, power state gating and clearing
	task automatic t_soft();
		apb(1'b1, pic_pkg::OFF_LOCAL_SET, 32'h0000_0010);
		apb(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_0020);
		apb(1'b1, pic_pkg::OFF_STAT_SET, 32'h0000_00FF);
		rdc(pic_pkg::OFF_STATUS, 32'h0000_00F0, "soft set");
		chk("local soft", {31'b0, localCpuIrq}, 32'h0000_0001);
		chk("host soft", {31'b0, hostIrqPinOe}, 32'h0000_0001);
		powerD0 <= 1'b0;
		repeat (8) @(posedge clk);
		chk("pin off d0", {31'b0, hostIrqPinOe}, 32'h0000_0000);
		powerD0 <= 1'b1;
		repeat (8) @(posedge clk);
		chk("pin in d0", {31'b0, hostIrqPinOe}, 32'h0000_0001);
		apb(1'b1, pic_pkg::OFF_STATUS, 32'h0000_0020);
		repeat (2) @(posedge clk);
		chk("soft clr", {31'b0, hostIrqPinOe}, 32'h0000_0000);
		chk("local kept", {31'b0, localCpuIrq}, 32'h0000_0001);
		apb(1'b1, pic_pkg::OFF_STATUS, 32'h0000_00FF);
	endtask : t_soft
	// hook values reach live words only on a pci reset
	task automatic t_hooks();
		rdc(pic_pkg::OFF_MIRROR_VD, HVD, "live vd rst");
		apb(1'b1, pic_pkg::OFF_HOOK_VD, 32'h0BAD_0F0D);
		rdc(pic_pkg::OFF_MIRROR_VD, HVD, "live kept");
		pciRst_n <= 1'b0;
		repeat (20) @(posedge clk);
		pciRst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rdc(pic_pkg::OFF_MIRROR_VD, 32'h0BAD_0F0D, "live vd");
		rdc(pic_pkg::OFF_MIRROR_CR, HCR, "live cr");
		apb(1'b1, pic_pkg::OFF_MIRROR_CR, 32'h0011_2233);
		rdc(pic_pkg::OFF_MIRROR_CR, 32'h0011_2233, "mirror");
	endtask : t_hooks
	// host path: closed window refused, open window reads and clears
	task automatic t_host();
		host_u.access(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_00FF);
		repeat (12) @(posedge clk);
		rdc(pic_pkg::OFF_HOST_SET, 32'h0000_0021, "closed win");
		apb(1'b1, pic_pkg::OFF_CONTROL, 32'h0000_0001);
		apb(1'b1, pic_pkg::OFF_STAT_SET, 32'h0000_0040);
		host_u.access(1'b1, pic_pkg::OFF_HOST_SET, 32'h0000_0040);
		repeat (12) @(posedge clk);
		chk("host en pin", {31'b0, hostIrqPinOe}, 32'h0000_0001);
		host_u.access(1'b0, pic_pkg::OFF_HOST_CLR, 32'h0000_0000);
		repeat (12) @(posedge clk);
		chk("host rd src", hostRdata, 32'h0000_0040);
		host_u.access(1'b1, pic_pkg::OFF_STATUS, 32'h0000_0040);
		repeat (12) @(posedge clk);
		chk("host clr pin", {31'b0, hostIrqPinOe}, 32'h0000_0000);
	endtask : t_host
	// reset, then the scenarios in turn
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pciRst_n = 1'b1;
		powerD0 = 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_masks();
		t_events();
		t_soft();
		t_hooks();
		t_host();
		end_of_test();
	end
endmodule : pci_interrupt_and_config_access_test

/* File: pic_host_model.sv */
// pci host side model: link clock, event strobes, target accesses
`timescale 1ns/1ps
module pic_host_model (
	output logic               pciClk,
	output pic_pkg::pic_evt_t  pciEvt,
	output pic_pkg::pic_host_t hostAcc
);
	// pci clock runs free on the bus, 80 ns period
	initial pciClk = 1'b0;
	always #40 pciClk = ~pciClk;
	// idle strobes and an idle access at time zero
	initial pciEvt = '0;
	initial hostAcc = '0;
	// one strobe, held a full pci period across one rise
	task automatic strobe(input logic [5:0] e);
		@(negedge pciClk) pciEvt <= e;
		@(negedge pciClk) pciEvt <= '0;
	endtask : strobe
	// released lines show the inverse, never the stale value
	// stands for a type 0 style target access by the host
	// host has set master and memory enables beforehand
	task automatic access(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(negedge pciClk) hostAcc <= {1'b1, w, a, d};
		@(negedge pciClk) hostAcc <= {1'b0, ~w, ~a, ~d};
	endtask : access
endmodule : pic_host_model

/* File: pic_irq_cfg.sv */
// interrupt routing and configuration hook logic of the pci function
//
// Overview of operation
// - pci reset loads hooks into live registers
// - software may rewrite hooks for later resets
// - flag parity error on master read/target write
// - flag system error on received target abort or address parity
// - flag master abort on own transaction
// - flag target abort when signalled as target
// - status routes to host, local, or both
// - host mask reached only via set/clear
// - host set: one enables, read gives mask
// - host clear: one disables, read status&mask
// - host pin signalling enabled in d0
// - host pin low while status&mask nonzero
// - soft bits raise host pin; either clears
// - local set: one enables, read gives mask
// - local clear: one disables, read status&mask
// - local request while status&local mask nonzero
// - status set writes raise soft bits
// - no dma request events produced
// - mirror writes update configuration registers
// - host reaches registers only through open window
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pic_irq_cfg #(
	parameter logic [31:0] HOOK_VD_RST = 32'h1234_5678, // arbitrary value
	parameter logic [31:0] HOOK_CR_RST = 32'h0000_0001  // arbitrary value
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// pci side, inputs all asynchronous to clk
	input  wire logic                pciClk,
	input  wire logic                pciRst_n,
	input  wire logic                powerD0,
	input  wire pic_pkg::pic_evt_t   pciEvt,
	input  wire pic_pkg::pic_host_t  hostAcc,
	output logic      [31:0]         hostRdata,
	// open-drain host interrupt wire
	input  wire logic                hostIrqPinIn,
	output logic                     hostIrqPinOut,
	output logic                     hostIrqPinOe,
	// local cpu
	output logic                     localCpuIrq
);
	pic_pkg::pic_state_t st_reg;  // registered state
	pic_pkg::pic_state_t st_next; // next state

	// register write effect, shared by apb and the host window
	function automatic pic_pkg::pic_state_t regWrite(
		input pic_pkg::pic_state_t s,
		input logic [7:0]          a,
		input logic [31:0]         d
	);
		pic_pkg::pic_state_t r;
		r = s;
		unique case (a)
			pic_pkg::OFF_STATUS:    r.status  = s.status & ~d[7:0];
			pic_pkg::OFF_STAT_SET:
				r.status = s.status | (d[7:0] & pic_pkg::SOFT_MASK);
			pic_pkg::OFF_HOST_SET:  r.hostEn  = s.hostEn | d[7:0];
			pic_pkg::OFF_HOST_CLR:  r.hostEn  = s.hostEn & ~d[7:0];
			pic_pkg::OFF_LOCAL_SET: r.localEn = s.localEn | d[7:0];
			pic_pkg::OFF_LOCAL_CLR: r.localEn = s.localEn & ~d[7:0];
			pic_pkg::OFF_HOOK_VD:   r.hookVd  = d;
			pic_pkg::OFF_HOOK_CR:   r.hookCr  = d;
			pic_pkg::OFF_MIRROR_VD: r.liveVd  = d;
			pic_pkg::OFF_MIRROR_CR: r.liveCr  = d;
			pic_pkg::OFF_CONTROL:   r.winEn   = d[pic_pkg::CTL_WIN_EN];
			default:                r = s; // unmapped or read-only
		endcase
		return r;
	endfunction : regWrite

	// register read value; bit 32 flags an unmapped offset
	function automatic logic [32:0] regRead(
		input pic_pkg::pic_state_t s,
		input logic [7:0]          a
	);
		logic [32:0] r;
		r = {1'b0, pic_pkg::ZERO_WORD};
		unique case (a)
			pic_pkg::OFF_STATUS,
			pic_pkg::OFF_STAT_SET:  r[7:0] = s.status;
			pic_pkg::OFF_HOST_SET:  r[7:0] = s.hostEn;
			pic_pkg::OFF_HOST_CLR:  r[7:0] = s.status & s.hostEn;
			pic_pkg::OFF_LOCAL_SET: r[7:0] = s.localEn;
			pic_pkg::OFF_LOCAL_CLR: r[7:0] = s.status & s.localEn;
			pic_pkg::OFF_HOOK_VD:   r[31:0] = s.hookVd;
			pic_pkg::OFF_HOOK_CR:   r[31:0] = s.hookCr;
			pic_pkg::OFF_MIRROR_VD: r[31:0] = s.liveVd;
			pic_pkg::OFF_MIRROR_CR: r[31:0] = s.liveCr;
			pic_pkg::OFF_CONTROL:   r[pic_pkg::CTL_WIN_EN] = s.winEn;
			pic_pkg::OFF_PIN_STATE: begin
				r[pic_pkg::PIN_IRQ_LVL] = s.pinS2;
				r[pic_pkg::PIN_D0]      = s.d0S2;
			end
			default:                r[32] = 1'b1;
		endcase
		return r;
	endfunction : regRead

	// next-state logic for the whole block
	always_comb begin
		logic        pciRise;  // sampled rising edge of pci clock
		logic        apbWr;    // apb write completes this cycle
		logic        hostOk;   // host access admitted
		logic [7:0]  evtSet;   // status bits raised by hardware
		logic [32:0] rd;       // read lookup result
		pciRise = 1'b0;
		apbWr   = 1'b0;
		hostOk  = 1'b0;
		evtSet  = pic_pkg::STATUS_RST;
		rd      = {1'b0, pic_pkg::ZERO_WORD};
		st_next = st_reg;

		// synchronisers; stage one feeds only stage two, except d0S1, which also feeds hostIrqOe
		st_next.clkS1  = pciClk;
		st_next.clkS2  = st_reg.clkS1;
		st_next.clkS3  = st_reg.clkS2;
		st_next.evtS1  = pciEvt;
		st_next.evtS2  = st_reg.evtS1;
		st_next.hostS1 = hostAcc;
		st_next.hostS2 = st_reg.hostS1;
		st_next.rstS1  = pciRst_n;
		st_next.rstS2  = st_reg.rstS1;
		st_next.d0S1   = powerD0;
		st_next.d0S2   = st_reg.d0S1;
		st_next.pinS1  = hostIrqPinIn;
		st_next.pinS2  = st_reg.pinS1;

		// pci-side strobes count once per pci clock, at its rise
		pciRise = st_reg.clkS2 & ~st_reg.clkS3;

		// hardware events
		if (pciRise) begin
			evtSet[pic_pkg::ST_PARITY] = st_reg.evtS2.parErrMasterRd
				| st_reg.evtS2.parErrTargetWr;
			evtSet[pic_pkg::ST_SYSERR] = st_reg.evtS2.rcvTargetAbort
				| st_reg.evtS2.addrParErr;
			evtSet[pic_pkg::ST_MABORT] = st_reg.evtS2.masterAbort;
			evtSet[pic_pkg::ST_TABORT] = st_reg.evtS2.targetAbortSig;
		end

		// apb: answer one cycle after setup, with registered data
		apbWr = psel & penable & pready & pwrite;
		if (apbWr) begin
			st_next = regWrite(st_next, paddr, pwdata);
		end
		rd = regRead(st_reg, paddr);
		st_next.pready  = psel & ~penable;
		st_next.prdata  = (psel & ~penable & ~pwrite) ? rd[31:0]
			: pic_pkg::ZERO_WORD;
		st_next.pslverr = psel & ~penable & rd[32];

		// host window; closed window ignores the access
		hostOk = pciRise & st_reg.hostS2.stb & st_reg.winEn;
		if (hostOk & st_reg.hostS2.wr) begin
			st_next = regWrite(st_next, st_reg.hostS2.addr,
				st_reg.hostS2.wdata);
		end
		if (hostOk & ~st_reg.hostS2.wr) begin
			rd = regRead(st_reg, st_reg.hostS2.addr);
			st_next.hostRdata = rd[31:0];
		end

		// hardware set wins over any clear in the same cycle
		st_next.status = st_next.status | evtSet;

		// pci reset copies hooks into live registers
		if (!st_reg.rstS2) begin
			st_next.liveVd = st_next.hookVd;
			st_next.liveCr = st_next.hookCr;
		end

		// interrupt outputs; each mask gates independently
		st_next.hostIrqOe = |(st_next.status & st_next.hostEn)
			& st_next.d0S2;
		st_next.localIrq  = |(st_next.status & st_next.localEn);
	end

	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg         <= '0;
			st_reg.clkS1   <= 1'b0;
			st_reg.rstS1   <= 1'b1;
			st_reg.rstS2   <= 1'b1;
			st_reg.status  <= pic_pkg::STATUS_RST;
			st_reg.hostEn  <= pic_pkg::ENABLE_RST;
			st_reg.localEn <= pic_pkg::ENABLE_RST;
			st_reg.hookVd  <= HOOK_VD_RST;
			st_reg.hookCr  <= HOOK_CR_RST;
			st_reg.liveVd  <= HOOK_VD_RST;
			st_reg.liveCr  <= HOOK_CR_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flops; wire is only ever pulled low
	// no dma request port exists at all
	assign prdata        = st_reg.prdata;
	assign pready        = st_reg.pready;
	assign pslverr       = st_reg.pslverr;
	assign hostRdata     = st_reg.hostRdata;
	assign hostIrqPinOut = 1'b0;
	assign hostIrqPinOe  = st_reg.hostIrqOe;
	assign localCpuIrq   = st_reg.localIrq;

	// helper for checks: host write landing in same cycle
	logic hostOkW;
	assign hostOkW = st_reg.clkS2 & ~st_reg.clkS3 & st_reg.hostS2.stb
		& st_reg.winEn & st_reg.hostS2.wr;

	// checks
	sequence s_apbWrite(logic [7:0] a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence

	a_host_pin_level: assert property (@(posedge clk) disable iff (sys_rst)
		##1 hostIrqPinOe == ((|($past(st_next.status) & $past(st_next.hostEn)))
		&& $past(st_next.d0S2)))
		else $error("host irq wire does not follow status and mask");
	a_local_irq: assert property (@(posedge clk) disable iff (sys_rst)
		(|(st_reg.status & st_reg.localEn)) |-> localCpuIrq)
		else $error("local request missing with enabled status");
	a_host_set_one: assert property (@(posedge clk) disable iff (sys_rst)
		s_apbWrite(pic_pkg::OFF_HOST_SET) |=>
		((st_reg.hostEn & $past(pwdata[7:0])) == $past(pwdata[7:0])))
		else $error("host enable set did not enable bits");
	a_host_clr_one: assert property (@(posedge clk) disable iff (sys_rst)
		s_apbWrite(pic_pkg::OFF_HOST_CLR) && !hostOkW |=>
		((st_reg.hostEn & $past(pwdata[7:0])) == 8'h00))
		else $error("host enable clear did not disable bits");
	a_mask_zero_keep: assert property (@(posedge clk) disable iff (sys_rst)
		s_apbWrite(pic_pkg::OFF_LOCAL_SET) && !hostOkW |=>
		((st_reg.localEn & ~$past(pwdata[7:0]))
		== ($past(st_reg.localEn) & ~$past(pwdata[7:0]))))
		else $error("zero bits changed the local mask");
	a_hook_load: assert property (@(posedge clk) disable iff (sys_rst)
		!st_reg.rstS2 |=> st_reg.liveVd == $past(st_next.hookVd))
		else $error("live word not loaded from hook in pci reset");
	a_soft_set: assert property (@(posedge clk) disable iff (sys_rst)
		s_apbWrite(pic_pkg::OFF_STAT_SET) |=>
		((st_reg.status & $past(pwdata[7:0]) & pic_pkg::SOFT_MASK)
		== ($past(pwdata[7:0]) & pic_pkg::SOFT_MASK)))
		else $error("status set did not raise soft bits");
	a_master_abort: assert property (@(posedge clk) disable iff (sys_rst)
		(st_reg.clkS2 && !st_reg.clkS3 && st_reg.evtS2.masterAbort)
		|=> st_reg.status[pic_pkg::ST_MABORT])
		else $error("master abort event lost");
	a_window_shut: assert property (@(posedge clk) disable iff (sys_rst)
		!st_reg.winEn && !(psel && penable) |=>
		$stable(st_reg.hostEn) && $stable(st_reg.hostRdata))
		else $error("host access went through a closed window");
endmodule : pic_irq_cfg

/* File: pic_pkg.sv */
// shared constants and carrier types for the pci interrupt block
package pic_pkg;
	// register bus geometry
	localparam int ADDR_W = 8;    // apb byte address width
	localparam int DATA_W = 32;   // apb data width
	localparam int ST_W   = 8;    // status and enable mask width
	localparam int SYNC_N = 2;    // flops in each input synchroniser

	// register byte offsets
	localparam logic [7:0] OFF_STATUS     = 8'h00; // read status, w1 clear
	localparam logic [7:0] OFF_STAT_SET   = 8'h04; // read status, w1 set soft
	localparam logic [7:0] OFF_HOST_SET   = 8'h08; // host enable set
	localparam logic [7:0] OFF_HOST_CLR   = 8'h0C; // host enable clear
	localparam logic [7:0] OFF_LOCAL_SET  = 8'h10; // local enable set
	localparam logic [7:0] OFF_LOCAL_CLR  = 8'h14; // local enable clear
	localparam logic [7:0] OFF_HOOK_VD    = 8'h18; // vendor/device hook
	localparam logic [7:0] OFF_HOOK_CR    = 8'h1C; // class/revision hook
	localparam logic [7:0] OFF_MIRROR_VD  = 8'h20; // vendor/device mirror
	localparam logic [7:0] OFF_MIRROR_CR  = 8'h24; // class/revision mirror
	localparam logic [7:0] OFF_CONTROL    = 8'h28; // slave window enable
	localparam logic [7:0] OFF_PIN_STATE  = 8'h2C; // pin and power levels

	// status bit positions
	localparam int ST_PARITY  = 0; // parity error
	localparam int ST_SYSERR  = 1; // system error
	localparam int ST_MABORT  = 2; // master abort
	localparam int ST_TABORT  = 3; // target abort
	localparam logic [7:0] SOFT_MASK = 8'hF0; // software interrupt bits

	// control and pin-state field positions
	localparam int CTL_WIN_EN  = 0; // host window onto registers open
	localparam int PIN_IRQ_LVL = 0; // sampled level of host irq wire
	localparam int PIN_D0      = 1; // power state is d0

	// reset values
	localparam logic [7:0]  ENABLE_RST = 8'h00;
	localparam logic [7:0]  STATUS_RST = 8'h00;
	localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

	// abnormal events reported by the pci core, one pci clock each
	typedef struct packed {
		logic parErrMasterRd;  // bad parity on read data as master
		logic parErrTargetWr;  // bad parity on write data as target
		logic rcvTargetAbort;  // target abort received as master
		logic addrParErr;      // address parity error seen on bus
		logic masterAbort;     // own transaction ended by master abort
		logic targetAbortSig;  // target abort signalled as target
	} pic_evt_t;

	// host access through the target interface
	typedef struct packed {
		logic        stb;    // access valid this pci clock
		logic        wr;     // write when high
		logic [7:0]  addr;   // byte offset
		logic [31:0] wdata;  // write data
	} pic_host_t;

	// entire state of the block
	typedef struct packed {
		logic        clkS1, clkS2, clkS3; // pci clock sampling
		pic_evt_t    evtS1, evtS2;        // event synchroniser
		pic_host_t   hostS1, hostS2;      // host access synchroniser
		logic        rstS1, rstS2;        // pci reset synchroniser
		logic        d0S1, d0S2;          // power state synchroniser
		logic        pinS1, pinS2;        // irq wire synchroniser
		logic [7:0]  status;              // internal status
		logic [7:0]  hostEn;              // hidden host enable mask
		logic [7:0]  localEn;             // hidden local enable mask
		logic [31:0] hookVd, hookCr;      // configuration hooks
		logic [31:0] liveVd, liveCr;      // live configuration words
		logic        winEn;               // host window open
		logic [31:0] prdata;              // apb read data
		logic        pready;              // apb ready
		logic        pslverr;             // apb error
		logic [31:0] hostRdata;           // host read data
		logic        hostIrqOe;           // host irq wire pulled low
		logic        localIrq;            // local cpu request
	} pic_state_t;
endpackage : pic_pkg
